// ### hw/kil_regs.svh
// Register offsets, field positions and reset values of the keypad interrupt latch
`ifndef KIL_REGS_SVH
`define KIL_REGS_SVH
// ----------------------------------------------------------------------------
// Register indices and byte addresses (AXI4-Lite, one aligned word each)
// ----------------------------------------------------------------------------
`define KIL_IDX_STATUS_CONTROL 8'h1A
`define KIL_IDX_PIN_ENABLE 8'h1B
`define KIL_ADDR_STATUS_CONTROL 8'h68
`define KIL_ADDR_PIN_ENABLE 8'h6C
`define KIL_ADDR_IRQ_STATUS 8'h70
`define KIL_ADDR_IRQ_MASK 8'h74
// ----------------------------------------------------------------------------
// Status and control fields
// ----------------------------------------------------------------------------
`define KIL_BIT_PENDING 3
`define KIL_BIT_ACK 2
`define KIL_BIT_MASK 1
`define KIL_BIT_SENS 0
// ----------------------------------------------------------------------------
// Event status bits
// ----------------------------------------------------------------------------
`define KIL_EVT_LATCH 0
`define KIL_EVT_ACK_BLOCKED 1
`define KIL_EVT_WIDTH 2
// ----------------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------------
`define KIL_RST_BYTE 8'h00
`define KIL_RST_EVT 2'h0
`define KIL_RESP_OKAY 2'h0
`define KIL_RESP_SLVERR 2'h2
`endif

// ### hw/kil_pkg.sv
// Types shared by the keypad interrupt latch modules
package kil_pkg;
  // --------------------------------------------------------------------------
  // Bus slave phases
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    KIL_BUS_IDLE = 2'b00,
    KIL_BUS_RESP = 2'b01
  } kil_bus_e;
  typedef logic [7:0] kil_byte_t;
endpackage : kil_pkg

// ### hw/kil_sync.sv
// Two-stage synchroniser for the eight keypad pins
`timescale 1ns/1ps
module kil_sync
  import kil_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [7:0] i_pins,
  output logic [7:0] o_pins
);
  typedef struct packed {
    logic [7:0] stage1_ff; // Read only by stage two
    logic [7:0] stage2_ff; // Safe copy
  } kil_sync_s;
  kil_sync_s cur_ff;
  kil_sync_s nxt_cur;
  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.stage1_ff = i_pins;
    nxt_cur.stage2_ff = cur_ff.stage1_ff;
  end
  // Idle keys are pulled high, so reset to all ones
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cur_ff <= {8'hFF, 8'hFF};
    end else begin
      cur_ff <= nxt_cur;
    end
  end
  assign o_pins = cur_ff.stage2_ff;
endmodule : kil_sync

// ### hw/kil_detect.sv
// Keypad request latch: edge or edge-and-level detection and clearing
`timescale 1ns/1ps
module kil_detect
  import kil_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [7:0] i_pins,
  input wire logic [7:0] i_enable,
  input wire logic i_sens_level,
  input wire logic i_ack,
  output logic o_latch,
  output logic o_set_evt
);
  typedef struct packed {
    logic all_high_ff; // Enabled pins were all high last cycle
    logic latch_ff; // Pending request
    logic ack_seen_ff; // Acknowledge waiting for pins to rise
  } kil_det_s;
  kil_det_s cur_ff;
  kil_det_s nxt_cur;
  logic any_low;
  logic set_req;
  // ----------------------------------------------------------------------------
  // Latch update
  // ----------------------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    any_low = |(~i_pins & i_enable);
    // Low after all high; in edge mode a second low pin is ignored
    set_req = any_low && cur_ff.all_high_ff;
    nxt_cur.all_high_ff = !any_low;
    if (i_sens_level) begin
      // Both acknowledge and all pins high needed, either order
      if (i_ack && cur_ff.latch_ff) begin
        nxt_cur.ack_seen_ff = 1'b1;
      end
      if ((cur_ff.ack_seen_ff || i_ack) && !any_low) begin
        nxt_cur.latch_ff = 1'b0;
        nxt_cur.ack_seen_ff = 1'b0;
      end
    end else begin
      nxt_cur.ack_seen_ff = 1'b0;
      if (i_ack) begin
        nxt_cur.latch_ff = 1'b0;
      end
    end
    // New edge wins over a clear in the same cycle
    if (set_req) begin
      nxt_cur.latch_ff = 1'b1;
      nxt_cur.ack_seen_ff = 1'b0;
    end
  end
  // Pins assumed high after reset, so a key already held low fires when first seen
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cur_ff <= {1'b1, 1'b0, 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end
  assign o_latch = cur_ff.latch_ff;
  assign o_set_evt = set_req;
  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  a_edge_sets_latch: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    set_req |=> cur_ff.latch_ff) else $error("Falling edge did not latch request");
  a_edge_mode_ack: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (!i_sens_level && i_ack && !set_req) |=> !cur_ff.latch_ff) else $error("Edge mode ack did not clear");
  a_level_holds_low: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_sens_level && cur_ff.latch_ff && any_low) |=> cur_ff.latch_ff) else $error("Level request dropped while low");
  c_level_clear: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_sens_level && cur_ff.ack_seen_ff && !any_low);
endmodule : kil_detect

// ### hw/kil_top.sv
// Keypad interrupt latch: AXI4-Lite registers, break protection and interrupt outputs
`timescale 1ns/1ps
`include "kil_regs.svh"
// Contract
// - Keeps running in stop; wakes when unmasked
// - Break clear only when clear enable set; vector fetch ack clears in break regardless
// - Break-time clear stays after break ends
// - Clear enable zero: break ack ignored
// - Control bits seven to four read zero
// - Pending flag read-only, shows latch
// - Ack write clears latch, reads zero
// - Mask one blocks CPU request
// - Sensitivity: one edge-level, zero edge
// - Eight pin enables, reset zero
// - Latch on low after all high
// - Level mode needs ack and pins high
// - Edge mode ack clears immediately
// - Pending flag ignores the mask
module kil_top
  import kil_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [7:0] i_port_a_pin,
  input wire logic i_break_state,
  input wire logic i_break_clear_enable,
  input wire logic i_vector_fetch_ack,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_cpu_irq,
  output logic o_wakeup,
  output logic o_irq
);
  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    kil_byte_t pin_enable_ff; // Pin enable bits
    logic request_mask_ff; // Blocks CPU request
    logic sensitivity_select_ff; // Edge-and-level when set
    logic [`KIL_EVT_WIDTH-1:0] evt_status_ff; // Sticky events
    logic [`KIL_EVT_WIDTH-1:0] evt_mask_ff; // Event enables
    logic aw_held_ff; // Write address taken
    logic [7:0] aw_addr_ff;
    logic w_held_ff; // Write data taken
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic cpu_irq_ff;
    logic wakeup_ff;
    logic irq_ff;
    logic awready_ff; // Write address channel free
    logic wready_ff; // Write data channel free
    logic arready_ff; // Read channel free
  } kil_top_s;
  kil_top_s cur_ff;
  kil_top_s nxt_cur;
  logic [7:0] pins_sync; // Synchronised keypad pins
  logic latch; // Pending request
  logic set_evt; // Request newly latched
  logic ack_write; // Software acknowledge this cycle
  logic ack_allowed; // Acknowledge after break protection
  logic ack_pulse; // Acknowledge into the latch
  logic wr_fire; // Write completes this cycle
  logic [7:0] cur_aw;
  logic [31:0] cur_w;
  logic [3:0] cur_s;
  logic [1:0] wr_resp;
  // Byte lane zero update, used by the pin enable write
  function automatic logic [7:0] kil_lane0(input logic [7:0] old_v, input logic [31:0] data,
                                           input logic [3:0] strb);
    kil_lane0 = strb[0] ? data[7:0] : old_v;
  endfunction : kil_lane0
  // ----------------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------------
  // Byte address is four times the register index
  // Control word: pending, ack, mask, sensitivity
  // Pin enable word: one bit per keypad pin
  // Event status: sticky, write one to clear
  // Event mask: same layout as event status
  // Anything else answers with an error
  // Address decode shared by read and write paths
  function automatic logic kil_mapped(input logic [7:0] addr);
    kil_mapped = (addr == `KIL_ADDR_STATUS_CONTROL) || (addr == `KIL_ADDR_PIN_ENABLE) ||
                 (addr == `KIL_ADDR_IRQ_STATUS) || (addr == `KIL_ADDR_IRQ_MASK);
  endfunction : kil_mapped
  // ----------------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------------
  kil_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_pins(i_port_a_pin),
    .o_pins(pins_sync)
  );
  // Runs on the bus clock with no stop gating, so stop mode leaves it active
  kil_detect u_detect (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_pins(pins_sync),
    .i_enable(cur_ff.pin_enable_ff),
    .i_sens_level(cur_ff.sensitivity_select_ff),
    .i_ack(ack_pulse),
    .o_latch(latch),
    .o_set_evt(set_evt)
  );
  // ----------------------------------------------------------------------------
  // Write path pieces
  // ----------------------------------------------------------------------------
  always_comb begin
    cur_aw = cur_ff.aw_held_ff ? cur_ff.aw_addr_ff : i_awaddr;
    cur_w = cur_ff.w_held_ff ? cur_ff.w_data_ff : i_wdata;
    cur_s = cur_ff.w_held_ff ? cur_ff.w_strb_ff : i_wstrb;
    // Both halves present now or earlier, and no response outstanding
    wr_fire = (cur_ff.aw_held_ff || i_awvalid) && (cur_ff.w_held_ff || i_wvalid) && !cur_ff.bvalid_ff;
    wr_resp = kil_mapped(cur_aw) ? `KIL_RESP_OKAY : `KIL_RESP_SLVERR;
    ack_write = wr_fire && (cur_aw == `KIL_ADDR_STATUS_CONTROL) && cur_s[0] && cur_w[`KIL_BIT_ACK];
    // Break blocks the ack write unless clear enable is set; vector fetch ack is not gated
    ack_allowed = ack_write && (!i_break_state || i_break_clear_enable);
    // A clear taken in break is a plain latch clear; nothing restores it later
    ack_pulse = ack_allowed || i_vector_fetch_ack;
  end
  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    // Address and data channels accepted independently
    if (!cur_ff.aw_held_ff && i_awvalid && !wr_fire) begin
      nxt_cur.aw_held_ff = 1'b1;
      nxt_cur.aw_addr_ff = i_awaddr;
    end
    if (!cur_ff.w_held_ff && i_wvalid && !wr_fire) begin
      nxt_cur.w_held_ff = 1'b1;
      nxt_cur.w_data_ff = i_wdata;
      nxt_cur.w_strb_ff = i_wstrb;
    end
    if (wr_fire) begin
      nxt_cur.aw_held_ff = 1'b0;
      nxt_cur.w_held_ff = 1'b0;
      nxt_cur.bvalid_ff = 1'b1;
      nxt_cur.bresp_ff = wr_resp;
      case (cur_aw)
        `KIL_ADDR_STATUS_CONTROL: begin
          nxt_cur.request_mask_ff = cur_s[0] ? cur_w[`KIL_BIT_MASK] : cur_ff.request_mask_ff;
          nxt_cur.sensitivity_select_ff = cur_s[0] ? cur_w[`KIL_BIT_SENS] : cur_ff.sensitivity_select_ff;
        end
        `KIL_ADDR_PIN_ENABLE: begin
          nxt_cur.pin_enable_ff = kil_lane0(cur_ff.pin_enable_ff, cur_w, cur_s);
        end
        `KIL_ADDR_IRQ_STATUS: begin
          // Write one to clear
          nxt_cur.evt_status_ff = cur_ff.evt_status_ff & ~(cur_s[0] ? cur_w[`KIL_EVT_WIDTH-1:0] : `KIL_RST_EVT);
        end
        `KIL_ADDR_IRQ_MASK: begin
          nxt_cur.evt_mask_ff = cur_s[0] ? cur_w[`KIL_EVT_WIDTH-1:0] : cur_ff.evt_mask_ff;
        end
        default: begin
          // Unmapped: error response only
        end
      endcase
    end
    if (cur_ff.bvalid_ff && i_bready) begin
      nxt_cur.bvalid_ff = 1'b0;
    end
    // Events set after the clear so a set in the same cycle wins
    if (set_evt) begin
      nxt_cur.evt_status_ff[`KIL_EVT_LATCH] = 1'b1;
    end
    if (ack_write && !ack_allowed) begin
      nxt_cur.evt_status_ff[`KIL_EVT_ACK_BLOCKED] = 1'b1;
    end
    // Read channel: one read at a time
    if (!cur_ff.rvalid_ff && i_arvalid) begin
      nxt_cur.rvalid_ff = 1'b1;
      nxt_cur.rresp_ff = kil_mapped(i_araddr) ? `KIL_RESP_OKAY : `KIL_RESP_SLVERR;
      case (i_araddr)
        `KIL_ADDR_STATUS_CONTROL: begin
          // Upper nibble zero, ack reads zero, pending ignores the mask
          nxt_cur.rdata_ff = {28'h0000000, latch, 1'b0, cur_ff.request_mask_ff,
                              cur_ff.sensitivity_select_ff};
        end
        `KIL_ADDR_PIN_ENABLE: nxt_cur.rdata_ff = {24'h000000, cur_ff.pin_enable_ff};
        `KIL_ADDR_IRQ_STATUS: nxt_cur.rdata_ff = {30'h00000000, cur_ff.evt_status_ff};
        `KIL_ADDR_IRQ_MASK: nxt_cur.rdata_ff = {30'h00000000, cur_ff.evt_mask_ff};
        default: nxt_cur.rdata_ff = 32'h00000000;
      endcase
    end else if (cur_ff.rvalid_ff && i_rready) begin
      nxt_cur.rvalid_ff = 1'b0;
    end
    // Ready taken from the next state, so each ready leaves a flop
    // Costs three flops, keeps the bus outputs glitch free
    nxt_cur.awready_ff = !nxt_cur.aw_held_ff && !nxt_cur.bvalid_ff;
    nxt_cur.wready_ff = !nxt_cur.w_held_ff && !nxt_cur.bvalid_ff;
    nxt_cur.arready_ff = !nxt_cur.rvalid_ff;
    // Outputs registered from the current latch; irq from the updated event status
    nxt_cur.cpu_irq_ff = latch && !cur_ff.request_mask_ff;
    nxt_cur.wakeup_ff = latch && !cur_ff.request_mask_ff;
    nxt_cur.irq_ff = |(nxt_cur.evt_status_ff & cur_ff.evt_mask_ff);
  end
  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cur_ff <= '0;
      // All channels free while in reset
      cur_ff.awready_ff <= 1'b1;
      cur_ff.wready_ff <= 1'b1;
      cur_ff.arready_ff <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end
  // Ready is high whenever the channel is free; payload is latched on take
  assign o_awready = cur_ff.awready_ff;
  assign o_wready = cur_ff.wready_ff;
  assign o_arready = cur_ff.arready_ff;
  assign o_bvalid = cur_ff.bvalid_ff;
  assign o_bresp = cur_ff.bresp_ff;
  assign o_rvalid = cur_ff.rvalid_ff;
  assign o_rdata = cur_ff.rdata_ff;
  assign o_rresp = cur_ff.rresp_ff;
  assign o_cpu_irq = cur_ff.cpu_irq_ff;
  assign o_wakeup = cur_ff.wakeup_ff;
  assign o_irq = cur_ff.irq_ff;
  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  a_break_protects: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (ack_write && i_break_state && !i_break_clear_enable && !i_vector_fetch_ack) |-> !ack_pulse)
    else $error("Protected break ack reached latch");
  a_break_clear_ok: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (ack_write && i_break_state && i_break_clear_enable) |-> ack_pulse) else $error("Allowed break ack lost");
  a_break_stays_clr: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (!latch && $fell(i_break_state) && !set_evt) |=> !latch) else $error("Leaving break restored request");
  a_mask_blocks: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (cur_ff.request_mask_ff && $stable(cur_ff.request_mask_ff)) |=> !o_cpu_irq) else $error("Masked request reached CPU");
  a_unmasked_irq: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (latch && !cur_ff.request_mask_ff) |=> o_wakeup) else $error("Unmasked request gave no wakeup");
  a_read_upper_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (o_arready && i_arvalid && i_araddr == `KIL_ADDR_STATUS_CONTROL) |=> o_rdata[7:4] == 4'h0 && !o_rdata[2])
    else $error("Control upper bits not zero");
  a_pending_reads: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (o_arready && i_arvalid && i_araddr == `KIL_ADDR_STATUS_CONTROL) |=> o_rdata[3] == $past(latch))
    else $error("Pending flag wrong");
  a_resp_held: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (o_bvalid && !i_bready) |=> o_bvalid && $stable(o_bresp)) else $error("Write response dropped");
  // ----------------------------------------------------------------------------
  // Event and bus checks
  // ----------------------------------------------------------------------------
  // A set and a clear together must leave the bit set
  a_evt_set_wins: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    set_evt |=> cur_ff.evt_status_ff[`KIL_EVT_LATCH]) else $error("Latch event lost");
  a_blocked_evt: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (ack_write && !ack_allowed) |=> cur_ff.evt_status_ff[`KIL_EVT_ACK_BLOCKED]) else $error("Blocked ack not flagged");
  a_rd_held: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (o_rvalid && !i_rready) |=> o_rvalid && $stable(o_rdata)) else $error("Read data dropped");
  a_ready_after: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (o_bvalid && i_bready) |=> o_awready && o_wready) else $error("Write channels not freed");
  a_bresp_error: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (wr_fire && !kil_mapped(cur_aw)) |=> o_bresp == `KIL_RESP_SLVERR) else $error("Unmapped write not refused");
  // Only lane zero carries the enable bits
  a_pin_write: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (wr_fire && cur_aw == `KIL_ADDR_PIN_ENABLE && cur_s[0]) |=> cur_ff.pin_enable_ff == $past(cur_w[7:0]))
    else $error("Pin enable write lost");
  c_edge_latch: cover property (@(posedge i_clk_sys) disable iff (!i_rstn) set_evt);
  c_break_clear: cover property (@(posedge i_clk_sys) disable iff (!i_rstn) ack_allowed && i_break_state);
  c_break_block: cover property (@(posedge i_clk_sys) disable iff (!i_rstn) ack_write && !ack_allowed);
  c_cpu_irq: cover property (@(posedge i_clk_sys) disable iff (!i_rstn) o_cpu_irq);
endmodule : kil_top

// ### verification/kil_keypad.sv
// Keypad switch model driving the port A pins of the keypad interrupt latch
`timescale 1ns/1ps
module kil_keypad
  import kil_pkg::*;
(
  input wire logic [7:0] i_press,
  output logic [7:0] o_pins
);
  // ---------------------------------------------------------------------------
  // Switches to ground with pull-ups
  // ---------------------------------------------------------------------------
  // A closed switch pulls its pin low; an open one is held high by its pull-up,
  // so a released pin never floats to an unknown level
  always_comb begin
    o_pins = ~i_press;
  end
endmodule : kil_keypad

// ### verification/keypad_interrupt_latch_tb.sv
// Self-checking testbench for the keypad interrupt latch
`timescale 1ns/1ps
`include "kil_regs.svh"
module keypad_interrupt_latch_tb
  import kil_pkg::*;
;
  // ---------------------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] press = 8'h00; // Keys held down
  logic [7:0] pins;
  logic brk = 1'b0; // Break state
  logic bce = 1'b0; // Break clear enable
  logic vfa = 1'b0; // Vector fetch acknowledge
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, cpu_irq, wakeup, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int bad_count = 0;
  int n_checks = 0;
  // 25 ns period
  always #12.5 clk = ~clk;
  kil_keypad i_keys (.i_press(press), .o_pins(pins));
  kil_top i_dut (
    .i_clk_sys(clk), .i_rstn(rstn), .i_port_a_pin(pins), .i_break_state(brk),
    .i_break_clear_enable(bce), .i_vector_fetch_ack(vfa), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_cpu_irq(cpu_irq), .o_wakeup(wakeup), .o_irq(irq)
  );
  // ---------------------------------------------------------------------------
  // Compare, bus and closing tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Outputs are compared at the falling edge, well away from updates
  task automatic out_chk(input logic e_cpu, input logic e_irq);
    @(negedge clk);
    chk("cpu_irq", {31'h0, e_cpu}, {31'h0, cpu_irq});
    chk("wakeup", {31'h0, e_cpu}, {31'h0, wakeup});
    chk("irq", {31'h0, e_irq}, {31'h0, irq});
    @(posedge clk);
  endtask : out_chk
  // Handshakes are sampled at the falling edge; inputs are steady until the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done, got;
    int n;
    aw_done = 1'b0;
    w_done = 1'b0;
    got = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50 && !(aw_done && w_done); n++) begin
      @(negedge clk);
      aw_done = aw_done | awready;
      w_done = w_done | wready;
      @(posedge clk);
      if (aw_done) awvalid <= 1'b0;
      if (w_done) wvalid <= 1'b0;
    end
    bready <= 1'b1;
    for (n = 0; n < 50 && !got; n++) begin
      @(negedge clk);
      got = bvalid;
      if (got) chk("bresp", 32'h0, {30'h0, bresp});
      @(posedge clk);
    end
    bready <= 1'b0;
  endtask : wr
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
    logic got;
    int n;
    got = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50 && !got; n++) begin
      @(negedge clk);
      got = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    got = 1'b0;
    for (n = 0; n < 50 && !got; n++) begin
      @(negedge clk);
      got = rvalid;
      if (got) begin
        chk("rdata", exp, rdata);
        chk("rresp", {30'h0, resp}, {30'h0, rresp});
      end
      @(posedge clk);
    end
    rready <= 1'b0;
  endtask : rd_exp
  // Pin to latch takes two synchroniser edges, one latch edge and one output edge
  task automatic keys(input logic [7:0] k);
    press <= k;
    repeat (6) @(posedge clk);
  endtask : keys
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  // ---------------------------------------------------------------------------
  // Watchdog: the tests need well under two thousand cycles
  // ---------------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end
  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd_exp(`KIL_ADDR_STATUS_CONTROL, 32'h0, `KIL_RESP_OKAY);
    rd_exp(`KIL_ADDR_PIN_ENABLE, 32'h0, `KIL_RESP_OKAY);
    rd_exp(8'h40, 32'h0, `KIL_RESP_SLVERR);
    wr(`KIL_ADDR_PIN_ENABLE, 32'hA5);
    rd_exp(`KIL_ADDR_PIN_ENABLE, 32'hA5, `KIL_RESP_OKAY);
    wr(`KIL_ADDR_PIN_ENABLE, 32'hFF);
    wr(`KIL_ADDR_STATUS_CONTROL, 32'hFFFFFFF6);
    rd_exp(`KIL_ADDR_STATUS_CONTROL, 32'h02, `KIL_RESP_OKAY);
    end_test("registers");
    // Edge mode: latch, ignored second edge, ack while pin still low
    wr(`KIL_ADDR_STATUS_CONTROL, 32'h0);
    wr(`KIL_ADDR_IRQ_MASK, 32'h1);
    keys(8'h01);
    out_chk(1'b1, 1'b1);
    rd_exp(`KIL_ADDR_STATUS_CONTROL, 32'h08, `KIL_RESP_OKAY);
    wr(`KIL_ADDR_STATUS_CONTROL, 32'h04);
    rd_exp(`KIL_ADDR_STATUS_CONTROL, 32'h0, `KIL_RESP_OKAY);
    keys(8'h03);
    rd_exp(`KIL_ADDR_STATUS_CONTROL, 32'h0, `KIL_RESP_OKAY);
    wr(`KIL_ADDR_IRQ_STATUS, 32'h3);
    out_chk(1'b0, 1'b0);
    keys(8'h00);
    keys(8'h08);
    vfa <= 1'b1;
    @(posedge clk);
    vfa <= 1'b0;
    rd_exp(`KIL_ADDR_STATUS_CONTROL, 32'h0, `KIL_RESP_OKAY);
    keys(8'h00);
    wr(`KIL_ADDR_PIN_ENABLE, 32'h7F);
    keys(8'h80);
    rd_exp(`KIL_ADDR_STATUS_CONTROL, 32'h0, `KIL_RESP_OKAY);
    keys(8'h00);
    wr(`KIL_ADDR_PIN_ENABLE, 32'hFF);
    end_test("edge");
    // Masked request still shows as pending
    wr(`KIL_ADDR_STATUS_CONTROL, 32'h02);
    keys(8'h80);
    rd_exp(`KIL_ADDR_STATUS_CONTROL, 32'h0A, `KIL_RESP_OKAY);
    out_chk(1'b0, 1'b1);
    wr(`KIL_ADDR_STATUS_CONTROL, 32'h06);
    keys(8'h00);
    end_test("mask");
    // Level mode needs both the acknowledge and all pins high
    wr(`KIL_ADDR_STATUS_CONTROL, 32'h01);
    keys(8'h10);
    vfa <= 1'b1;
    @(posedge clk);
    vfa <= 1'b0;
    repeat (3) @(posedge clk);
    rd_exp(`KIL_ADDR_STATUS_CONTROL, 32'h09, `KIL_RESP_OKAY);
    keys(8'h00);
    rd_exp(`KIL_ADDR_STATUS_CONTROL, 32'h01, `KIL_RESP_OKAY);
    end_test("level");
    // Break protection of the latch
    wr(`KIL_ADDR_STATUS_CONTROL, 32'h0);
    keys(8'h04);
    keys(8'h00);
    brk <= 1'b1;
    wr(`KIL_ADDR_STATUS_CONTROL, 32'h04);
    rd_exp(`KIL_ADDR_STATUS_CONTROL, 32'h08, `KIL_RESP_OKAY);
    rd_exp(`KIL_ADDR_IRQ_STATUS, 32'h3, `KIL_RESP_OKAY);
    bce <= 1'b1;
    wr(`KIL_ADDR_STATUS_CONTROL, 32'h04);
    rd_exp(`KIL_ADDR_STATUS_CONTROL, 32'h0, `KIL_RESP_OKAY);
    brk <= 1'b0;
    bce <= 1'b0;
    repeat (2) @(posedge clk);
    rd_exp(`KIL_ADDR_STATUS_CONTROL, 32'h0, `KIL_RESP_OKAY);
    wr(`KIL_ADDR_IRQ_STATUS, 32'h3);
    rd_exp(`KIL_ADDR_IRQ_STATUS, 32'h0, `KIL_RESP_OKAY);
    out_chk(1'b0, 1'b0);
    end_test("break");
    test_done();
  end
endmodule : keypad_interrupt_latch_tb
